// File: bench/gtpf_framer_chk.sv
// Stream assertions for the GPS time packet framer
`timescale 1ns/1ps
`default_nettype none
module gtpf_framer_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Frame stream
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    input wire logic txReady
);
    logic [9:0] byteIdx_q;
    logic [9:0] byteIdx_d;
    assign byteIdx_d = txLast ? 10'h000 : byteIdx_q + 10'h001;
    always_ff @(posedge sys_clk)
        if (!nrst) byteIdx_q <= 10'h000;
        else if (txValid && txReady) byteIdx_q <= byteIdx_d;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_dst_bcast: assert property (txValid && byteIdx_q < 10'h006 |-> txData == 8'hff)
        else $error("destination not broadcast");
    a_eth_type: assert property (txValid && byteIdx_q == 10'h00c |-> txData == 8'h08)
        else $error("bad ether type");
    a_frame_len: assert property (txValid && txLast |-> byteIdx_q == 10'h229)
        else $error("bad frame length");
    a_udp_port: assert property (txValid && byteIdx_q == 10'h023 |-> txData == 8'h10)
        else $error("bad source port");
    a_udp_len: assert property (txValid && byteIdx_q == 10'h027 |-> txData == 8'h08)
        else $error("bad udp length");
    a_ip_proto: assert property (txValid && byteIdx_q == 10'h017 |-> txData == 8'h11)
        else $error("bad ip protocol");
    a_pay_mark: assert property (txValid && byteIdx_q == 10'h02b |-> txData == 8'hee)
        else $error("bad payload marker");
    a_fill_byte: assert property (txValid && byteIdx_q inside {[144:547]} |-> txData == 8'hdf)
        else $error("bad fill byte");
    a_udp_csum: assert property (txValid && byteIdx_q inside {40, 41} |-> txData == 8'h00)
        else $error("nonzero udp checksum");
    a_frame_gap: assert property (txValid && txReady && txLast |=> !txValid)
        else $error("no gap after frame");
endmodule // gtpf_framer_chk
bind gtpf_framer gtpf_framer_chk gtpf_framer_chk_inst (.sys_clk(sys_clk), .nrst(nrst),
    .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady));
`default_nettype wire

// File: bench/gtpf_gps_model.sv
// Satellite receiver model: PPS pulse and sentence characters
`timescale 1ns/1ps
`default_nettype none
module gtpf_gps_model #(
    parameter int PPS_CYC = 20000
) (
    // Clock and pulse enable
    input wire logic sys_clk,
    input wire logic ppsOn,
    // Receiver outputs
    output logic ppsIn,
    output logic rxValid,
    output logic [7:0] rxData
);
    int cnt = 0;
    initial begin
        ppsIn = 1'b0;
        rxValid = 1'b0;
        rxData = 8'h00;
    end
    always @(posedge sys_clk) begin
        cnt <= (ppsOn && cnt < PPS_CYC - 1) ? cnt + 1 : 0;
        ppsIn <= ppsOn && cnt < 10;
    end
    // Idle data is inverted so a stale character never looks valid
    task send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge sys_clk);
            rxValid <= 1'b1;
            rxData <= s[i];
            @(posedge sys_clk);
            rxValid <= 1'b0;
            rxData <= ~s[i];
        end
    endtask
endmodule // gtpf_gps_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench for the GPS time packet framer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gtpf_pkg::*;
    localparam string SENT = "$GPRMC,072242,A,3027.3680,N,11423.6975,E,000.0,316.7,160617,004.1,W*67";
    localparam string SENT2 = "$GPGGA,072242,4807.038,N,01131.000,E,1,08,0.9,545.4,M,46.9,M,,*47";
    localparam string DT = "716061242270";
    logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, txReady = 0, ppsOn = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ppsIn, rxValid, txValid, txLast;
    logic [7:0] rxData, txData;
    logic [7:0] fr [0:553];
    int errors = 0, cmp_count = 0, n;
    gtpf_framer #(.NMEA_TMO(40000), .US_PER_S(205)) gtpf_framer_inst (.sys_clk(sys_clk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ppsIn(ppsIn),
        .rxValid(rxValid), .rxData(rxData), .txValid(txValid), .txData(txData),
        .txLast(txLast), .txReady(txReady));
    gtpf_gps_model #(.PPS_CYC(15000)) gtpf_gps_model_inst (.sys_clk(sys_clk), .ppsOn(ppsOn),
        .ppsIn(ppsIn), .rxValid(rxValid), .rxData(rxData));
    initial forever #5 sys_clk = ~sys_clk;
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Sink stalls every third cycle to exercise the hold behaviour
    task grab;
        int k;
        n = 0;
        k = 0;
        while (n < 554 && k < 40000) begin
            @(posedge sys_clk);
            k++;
            if (txValid === 1'b1 && txReady === 1'b1) begin
                fr[n] = txData;
                n++;
            end
            txReady <= (k % 3 != 0);
        end
        check(n, 554);
    endtask
    task frame_chk(input string s, input logic [7:0] st, input logic [7:0] pps);
        logic [31:0] sum;
        sum = 0;
        for (int i = 14; i < 34; i += 2) sum += {fr[i], fr[i + 1]};
        sum = sum[15:0] + sum[31:16];
        sum = sum[15:0] + sum[31:16];
        check(sum, 32'hffff);
        check({fr[16], fr[17]}, 32'h21c);
        check({fr[26], fr[27], fr[28], fr[29]}, SRC_IP_RST);
        check({fr[30], fr[31], fr[32], fr[33]}, 32'hffffffff);
        for (int i = 0; i < 12; i++) check(fr[44 + i], DT[i]);
        for (int i = 0; i < s.len(); i++) check(fr[60 + i], s[i]);
        check(fr[548], st);
        check(fr[549], pps);
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (80000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        apb(0, REG_SRC_IP, 0);
        check(rd, SRC_IP_RST);
        apb(0, 8'h40, 0);
        check(err, 1);
        gtpf_gps_model_inst.send(SENT);
        apb(0, REG_STATUS, 0);
        check(rd[STAT_NMEA_BIT], 1);
        grab();
        frame_chk(SENT, 8'h41, 8'h00);
        $display("free running frame test done");
        ppsOn <= 1'b1;
        apb(1, REG_CTRL, 32'h2);
        gtpf_gps_model_inst.send(SENT2);
        grab();
        frame_chk(SENT2, 8'h31, 8'h01);
        apb(0, REG_USEC, 0);
        check(rd < 32'd20, 1);
        apb(0, REG_STATUS, 0);
        check(rd[STAT_PPS_BIT], 1);
        $display("pps locked frame test done");
        apb(1, REG_CTRL, 32'h1);
        n = 0;
        repeat (22000) begin
            @(posedge sys_clk);
            if (txValid !== 1'b0) n++;
        end
        check(n, 0);
        apb(0, REG_STATUS, 0);
        check(rd[STAT_NMEA_BIT], 0);
        $display("time protocol and timeout test done");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire

// File: core/gtpf_framer.sv
// GPS time packet framer: sentence capture, APB registers and frame builder
//
// How it works
// R1: With satellite time source, one time packet leaves every second.
// R2: With precision time protocol selected, no time packet is sent.
// R3: Payload numbers are unsigned, least significant byte first.
// R4: IPv4 source address resets to 192.168.1.201, software may change it.
// R5: IPv4 and Ethernet destinations are all-ones broadcast.
// R6: Header is 42 bytes: MACs, type 0x0800, IPv4, UDP.
// R7: UDP ports are 10000 source and 10110 destination.
// R8: UDP length field holds 520.
// R9: IPv4 fields fixed: v4, 20 bytes, length 540, DF, TTL 64, UDP, checksum.
// R10: Payload opens with 0xff 0xee, then date digits, low digit first.
// R11: Second, minute, hour digits follow, low digit first, then 4 reserved.
// R12: 84-byte field copies the received sentence text.
// R13: RMC accepted when field one is time and field nine date.
// R14: GGA accepted when field one carries the time.
// R15: RMC status byte is location status, or zero while unlocked.
// R16: GGA status byte is the fix quality digit as received.
// R17: PPS lock byte follows status, then four reserved bytes.
// R18: A microsecond counter runs from the common time base.
// R19: Every PPS rising edge clears the microsecond counter.
// R20: Sentence status unlocks after 2 s without a valid sentence.
// R21: Pulse status is locked only while synchronised to PPS.
// R22: The 404-byte reserved region is filled with 0xdf.
// R23: UDP checksum is sent as zero.
`timescale 1ns/1ps
`default_nettype none
module gtpf_framer
    import gtpf_pkg::*;
#(
    parameter int NMEA_TMO = NMEA_TMO_CYC,
    parameter int US_PER_S = US_PER_SEC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Satellite receiver
    input wire logic ppsIn,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    // Frame byte stream towards the MAC
    output logic txValid,
    output logic [7:0] txData,
    output logic txLast,
    input wire logic txReady
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        gtpf_tx_e state;
        logic [9:0] idx;
        logic [7:0] txData;
        logic txValid;
        logic ptpSel;
        logic ggaSel;
        logic [31:0] srcIp;
        logic [47:0] mac;
        logic [31:0] prdata;
        logic pslverr;
        logic inSent;
        logic [6:0] rxIdx;
        logic [3:0] fieldNo;
        logic [3:0] fieldPos;
        logic [1:0] starCnt;
        logic [23:0] tType;
        logic [47:0] tTime;
        logic [47:0] tDate;
        logic [7:0] tStat;
        logic wrBank;
        logic rdBank;
        logic [47:0] time_;
        logic [47:0] date;
        logic [7:0] stat;
        logic [47:0] sTime;
        logic [47:0] sDate;
        logic [7:0] sStat;
        logic sPps;
        logic sBank;
        logic [27:0] nmeaCnt;
        logic nmeaLock;
        logic [15:0] ident;
        logic [31:0] pktCnt;
    } gtpf_fr_s;

    gtpf_fr_s q, d;
    // Two banks of 128 bytes; only the first 84 of each are used
    logic [7:0] sentMem [0:255];
    logic memWe;
    logic [7:0] memWa;
    logic [7:0] memRa;
    logic [7:0] memRd;
    logic [31:0] usCount;
    logic ppsLock;
    logic secTick;
    logic [9:0] nIdx;
    logic [9:0] pIdx;
    logic [7:0] nByte;
    logic apbSetup;
    logic apbWrite;
    logic sentDone;
    logic typeOk;
    logic [15:0] hdrCsum;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] ipCsum(input logic [31:0] ip, input logic [15:0] id);
        logic [19:0] s;
        logic [16:0] f;
        s = 20'(IP_VER_IHL_TOS) + 20'(IP_TOT_LEN) + 20'(id) + 20'(IP_FLAG_FRAG)
            + 20'(IP_TTL_PROTO) + 20'(ip[31:16]) + 20'(ip[15:0]) + 20'h1fffe;
        f = 17'(s[15:0]) + 17'(s[19:16]);
        return ~(f[15:0] + 16'(f[16]));
    endfunction

    function automatic logic [7:0] pick(input logic [47:0] v, input logic [9:0] k);
        return v[8 * k[2:0] +: 8];
    endfunction

    // ----------------------------------------------------------------
    // Microsecond timer
    // ----------------------------------------------------------------
    gtpf_us_timer #(
        .US_PER_S(US_PER_S)
    ) u_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ppsIn(ppsIn),
        .usCount(usCount),
        .ppsLock(ppsLock),
        .secTick(secTick)
    );

    // ----------------------------------------------------------------
    // Sentence buffer
    // ----------------------------------------------------------------
    assign memWe = rxValid && (rxData == CH_DOLLAR || (q.inSent && q.rxIdx < 7'(SENT_LEN)));
    assign memWa = {q.wrBank, (rxData == CH_DOLLAR) ? 7'd0 : q.rxIdx};
    assign memRa = {q.sBank, 7'(pIdx - 10'(P_SENT))};
    assign memRd = sentMem[memRa];

    always_ff @(posedge sys_clk) begin
        if (memWe) begin
            sentMem[memWa] <= rxData; // R12
        end
    end

    // ----------------------------------------------------------------
    // Frame byte generator
    // ----------------------------------------------------------------
    assign nIdx = (q.state == TX_IDLE) ? 10'd0 : q.idx + 10'd1;
    assign pIdx = nIdx - 10'(HDR_LEN);
    assign hdrCsum = ipCsum(q.srcIp, q.ident);

    always_comb begin
        nByte = 8'h00;
        if (nIdx < 10'd6) begin
            nByte = 8'hff; // R5
        end else if (nIdx < 10'd12) begin
            nByte = q.mac[8 * (11 - nIdx) +: 8];
        end else if (nIdx == 10'd12) begin
            nByte = ETH_TYPE[15:8]; // R6
        end else if (nIdx == 10'd13) begin
            nByte = ETH_TYPE[7:0]; // R6
        end else if (nIdx == 10'd14) begin
            nByte = IP_VER_IHL_TOS[15:8]; // R9
        end else if (nIdx == 10'd15) begin
            nByte = IP_VER_IHL_TOS[7:0]; // R9
        end else if (nIdx == 10'd16) begin
            nByte = IP_TOT_LEN[15:8]; // R9
        end else if (nIdx == 10'd17) begin
            nByte = IP_TOT_LEN[7:0]; // R9
        end else if (nIdx == 10'd18) begin
            nByte = q.ident[15:8];
        end else if (nIdx == 10'd19) begin
            nByte = q.ident[7:0];
        end else if (nIdx == 10'd20) begin
            nByte = IP_FLAG_FRAG[15:8]; // R9
        end else if (nIdx == 10'd21) begin
            nByte = IP_FLAG_FRAG[7:0]; // R9
        end else if (nIdx == 10'd22) begin
            nByte = IP_TTL_PROTO[15:8]; // R9
        end else if (nIdx == 10'd23) begin
            nByte = IP_TTL_PROTO[7:0]; // R9
        end else if (nIdx == 10'd24) begin
            nByte = hdrCsum[15:8]; // R9
        end else if (nIdx == 10'd25) begin
            nByte = hdrCsum[7:0]; // R9
        end else if (nIdx < 10'd30) begin
            nByte = q.srcIp[8 * (29 - nIdx) +: 8]; // R4
        end else if (nIdx < 10'd34) begin
            nByte = 8'hff; // R5
        end else if (nIdx == 10'd34) begin
            nByte = UDP_SRC_PORT[15:8]; // R7
        end else if (nIdx == 10'd35) begin
            nByte = UDP_SRC_PORT[7:0]; // R7
        end else if (nIdx == 10'd36) begin
            nByte = UDP_DST_PORT[15:8]; // R7
        end else if (nIdx == 10'd37) begin
            nByte = UDP_DST_PORT[7:0]; // R7
        end else if (nIdx == 10'd38) begin
            nByte = UDP_LEN[15:8]; // R8
        end else if (nIdx == 10'd39) begin
            nByte = UDP_LEN[7:0]; // R8
        end else if (nIdx < 10'(HDR_LEN)) begin
            nByte = UDP_CSUM[7:0]; // R23
        end else if (pIdx == 10'd0) begin
            nByte = PAY_MARK[15:8]; // R10
        end else if (pIdx == 10'd1) begin
            nByte = PAY_MARK[7:0]; // R10
        end else if (pIdx < 10'(P_TIME)) begin
            nByte = pick(q.sDate, pIdx - 10'(P_DATE)); // R10 R3
        end else if (pIdx < 10'(P_TIME + 6)) begin
            nByte = pick(q.sTime, pIdx - 10'(P_TIME)); // R11 R3
        end else if (pIdx < 10'(P_SENT)) begin
            nByte = 8'h00; // R11
        end else if (pIdx < 10'(P_FILL)) begin
            nByte = memRd; // R12
        end else if (pIdx < 10'(P_STAT)) begin
            nByte = FILL_BYTE; // R22
        end else if (pIdx == 10'(P_STAT)) begin
            nByte = q.sStat; // R15 R16
        end else if (pIdx == 10'(P_PPS)) begin
            nByte = {7'd0, q.sPps}; // R17
        end
    end

    // ----------------------------------------------------------------
    // Sentence decode
    // ----------------------------------------------------------------
    assign typeOk = q.ggaSel ? (q.tType == TYPE_GGA) : (q.tType == TYPE_RMC); // R13 R14
    assign sentDone = rxValid && q.inSent && q.starCnt == 2'd2 && rxData != CH_DOLLAR;

    // ----------------------------------------------------------------
    // APB
    // ----------------------------------------------------------------
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite;
    // Read data is latched in the setup cycle, so no wait state is needed
    assign pready = 1'b1;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr & psel & penable;
    assign txValid = q.txValid;
    assign txData = q.txData;
    assign txLast = q.txValid && q.idx == LAST_IDX;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // Register access
        if (apbSetup) begin
            d.pslverr = 1'b0;
            d.prdata = 32'h0;
            if (paddr == REG_CTRL) begin
                d.prdata[CTRL_PTP_BIT] = q.ptpSel;
                d.prdata[CTRL_GGA_BIT] = q.ggaSel;
            end else if (paddr == REG_SRC_IP) begin
                d.prdata = q.srcIp;
            end else if (paddr == REG_MAC_LO) begin
                d.prdata = q.mac[31:0];
            end else if (paddr == REG_MAC_HI) begin
                d.prdata = {16'h0, q.mac[47:32]};
            end else if (paddr == REG_STATUS) begin
                d.prdata[STAT_NMEA_BIT] = q.nmeaLock; // R20
                d.prdata[STAT_PPS_BIT] = ppsLock; // R21
                d.prdata[STAT_BUSY_BIT] = q.state == TX_SEND;
            end else if (paddr == REG_USEC) begin
                d.prdata = usCount; // R18
            end else if (paddr == REG_PKT_CNT) begin
                d.prdata = q.pktCnt;
            end else begin
                d.pslverr = 1'b1;
            end
        end
        if (apbWrite) begin
            if (paddr == REG_CTRL) begin
                d.ptpSel = pwdata[CTRL_PTP_BIT];
                d.ggaSel = pwdata[CTRL_GGA_BIT];
            end else if (paddr == REG_SRC_IP) begin
                d.srcIp = pwdata; // R4
            end else if (paddr == REG_MAC_LO) begin
                d.mac[31:0] = pwdata;
            end else if (paddr == REG_MAC_HI) begin
                d.mac[47:32] = pwdata[15:0];
            end
        end
        // Sentence capture
        if (q.nmeaCnt < 28'(NMEA_TMO)) begin
            d.nmeaCnt = q.nmeaCnt + 28'd1;
        end else begin
            d.nmeaLock = 1'b0; // R20
        end
        if (rxValid) begin
            if (rxData == CH_DOLLAR) begin
                d.inSent = 1'b1;
                d.rxIdx = 7'd1;
                d.fieldNo = 4'd0;
                d.fieldPos = 4'd0;
                d.starCnt = 2'd0;
                d.tStat = 8'h00; // R15
            end else if (q.inSent) begin
                if (q.rxIdx < 7'(SENT_LEN)) begin
                    d.rxIdx = q.rxIdx + 7'd1;
                end
                if (q.rxIdx >= 7'd3 && q.rxIdx <= 7'd5) begin
                    d.tType = {q.tType[15:0], rxData};
                end
                if (q.starCnt != 2'd0) begin
                    d.starCnt = q.starCnt + 2'd1;
                end else if (rxData == CH_STAR) begin
                    d.starCnt = 2'd1;
                end else if (rxData == CH_COMMA) begin
                    d.fieldNo = (q.fieldNo == 4'hf) ? q.fieldNo : q.fieldNo + 4'd1;
                    d.fieldPos = 4'd0;
                end else begin
                    d.fieldPos = (q.fieldPos == 4'hf) ? q.fieldPos : q.fieldPos + 4'd1;
                    // Digits past the sixth are fractional seconds and are dropped
                    if (q.fieldNo == FLD_TIME && q.fieldPos < 4'd6) begin
                        d.tTime = {q.tTime[39:0], rxData}; // R13 R14
                    end
                    if (!q.ggaSel && q.fieldNo == FLD_RMC_DATE && q.fieldPos < 4'd6) begin
                        d.tDate = {q.tDate[39:0], rxData}; // R13
                    end
                    if (q.fieldPos == 4'd0 && ((!q.ggaSel && q.fieldNo == FLD_RMC_STAT)
                            || (q.ggaSel && q.fieldNo == FLD_GGA_QUAL))) begin
                        d.tStat = rxData; // R15 R16
                    end
                end
            end
        end
        if (sentDone) begin
            d.inSent = 1'b0;
            if (typeOk) begin
                d.time_ = q.tTime;
                if (!q.ggaSel) begin
                    d.date = q.tDate;
                end
                d.stat = q.tStat;
                d.rdBank = q.wrBank;
                d.wrBank = ~q.wrBank;
                d.nmeaCnt = 28'd0;
                d.nmeaLock = 1'b1; // R20
            end
        end
        // Frame transmit
        case (q.state)
            TX_IDLE: begin
                if (secTick && !q.ptpSel) begin // R1 R2
                    d.state = TX_SEND;
                    d.idx = 10'd0;
                    d.txData = nByte;
                    d.txValid = 1'b1;
                    d.ident = q.ident + 16'd1;
                    d.pktCnt = q.pktCnt + 32'd1;
                    d.sTime = q.time_;
                    d.sDate = q.date;
                    // Location status reads zero while the sentence stream is lost
                    d.sStat = (!q.ggaSel && !q.nmeaLock) ? 8'h00 : q.stat; // R15
                    d.sPps = ppsLock; // R17
                    d.sBank = q.rdBank;
                end
            end
            TX_SEND: begin
                if (txReady) begin
                    if (q.idx == LAST_IDX) begin
                        d.state = TX_IDLE;
                        d.txValid = 1'b0;
                    end else begin
                        d.idx = nIdx;
                        d.txData = nByte;
                    end
                end
            end
            default: begin
                d.state = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q <= '0;
            q.srcIp <= SRC_IP_RST; // R4
            q.mac <= MAC_RST;
        end else begin
            q <= d;
        end
    end
endmodule // gtpf_framer
`default_nettype wire

// File: core/gtpf_us_timer.sv
// Microsecond counter, PPS edge detect, PPS lock and the once-per-second tick
`timescale 1ns/1ps
`default_nettype none
module gtpf_us_timer
    import gtpf_pkg::*;
#(
    parameter int US_PER_S = US_PER_SEC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Pulse per second
    input wire logic ppsIn,
    // Time outputs
    output logic [31:0] usCount,
    output logic ppsLock,
    output logic secTick
);
    typedef struct packed {
        logic ppsPrev;
        logic [6:0] sub;
        logic [31:0] us;
        logic lock;
    } gtpf_tm_s;

    gtpf_tm_s q, d;
    logic ppsRise;
    logic usStep;
    logic [31:0] wrapAt;

    assign ppsRise = ppsIn & ~q.ppsPrev;
    assign usStep = (q.sub == 7'(CYC_PER_US - 1));
    // Locked: a late pulse still counts; unlocked: free run at one second
    assign wrapAt = q.lock ? 32'(US_PER_S + PPS_TOL_US) : 32'(US_PER_S - 1);
    assign secTick = q.lock ? ppsRise : (usStep && q.us == 32'(US_PER_S - 1)); // R1
    assign usCount = q.us;
    assign ppsLock = q.lock;

    always_comb begin
        d = q;
        d.ppsPrev = ppsIn;
        d.sub = usStep ? 7'd0 : q.sub + 7'd1;
        if (ppsRise) begin
            d.us = 32'd0; // R19
            d.sub = 7'd0;
            d.lock = (q.us >= 32'(US_PER_S - PPS_TOL_US)); // R21
        end else if (usStep) begin
            if (q.us >= wrapAt) begin
                d.us = 32'd0;
                d.lock = 1'b0; // R21
            end else begin
                d.us = q.us + 32'd1; // R18
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // gtpf_us_timer
`default_nettype wire

// File: include/gtpf_pkg.sv
// Constants shared by the GPS time packet framer and its microsecond timer
package gtpf_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam int US_PER_SEC = 1000000;
    localparam int PPS_TOL_US = 100;
    localparam int NMEA_TMO_MS = 2000;
    localparam int NMEA_TMO_CYC = NMEA_TMO_MS * (1000000 / CLK_PERIOD_NS);
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SRC_IP = 8'h04;
    localparam logic [7:0] REG_MAC_LO = 8'h08;
    localparam logic [7:0] REG_MAC_HI = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_USEC = 8'h14;
    localparam logic [7:0] REG_PKT_CNT = 8'h18;
    localparam int CTRL_PTP_BIT = 0;
    localparam int CTRL_GGA_BIT = 1;
    localparam int STAT_NMEA_BIT = 0;
    localparam int STAT_PPS_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam logic [31:0] SRC_IP_RST = 32'hc0a801c9;
    // Arbitrary neutral station address
    localparam logic [47:0] MAC_RST = 48'h02_00_00_00_00_01;
    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int HDR_LEN = 42;
    localparam int PAY_LEN = 512;
    localparam logic [9:0] LAST_IDX = 10'(HDR_LEN + PAY_LEN - 1);
    localparam logic [15:0] ETH_TYPE = 16'h0800;
    localparam logic [15:0] IP_VER_IHL_TOS = 16'h4500;
    localparam logic [15:0] IP_TOT_LEN = 16'd540;
    localparam logic [15:0] IP_FLAG_FRAG = 16'h4000;
    localparam logic [15:0] IP_TTL_PROTO = 16'h4011;
    localparam logic [15:0] UDP_SRC_PORT = 16'h2710;
    localparam logic [15:0] UDP_DST_PORT = 16'h277e;
    localparam logic [15:0] UDP_LEN = 16'h0208;
    localparam logic [15:0] UDP_CSUM = 16'h0000;
    localparam logic [15:0] PAY_MARK = 16'hffee;
    localparam logic [7:0] FILL_BYTE = 8'hdf;
    localparam int SENT_LEN = 84;
    localparam int P_DATE = 2;
    localparam int P_TIME = 8;
    localparam int P_SENT = 18;
    localparam int P_FILL = 102;
    localparam int P_STAT = 506;
    localparam int P_PPS = 507;
    // ----------------------------------------------------------------
    // Sentence characters
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [23:0] TYPE_RMC = 24'h524d43;
    localparam logic [23:0] TYPE_GGA = 24'h474741;
    localparam logic [3:0] FLD_TIME = 4'd1;
    localparam logic [3:0] FLD_RMC_STAT = 4'd2;
    localparam logic [3:0] FLD_GGA_QUAL = 4'd6;
    localparam logic [3:0] FLD_RMC_DATE = 4'd9;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } gtpf_tx_e;
endpackage
